//--- hw/pmwg_pkg.sv
// Constants and types for the program memory write guard
package pmwg_pkg;
   localparam int ADDR_W        = 24;
   localparam int PAGE_SHIFT    = 9;
   localparam int PG_W          = ADDR_W - PAGE_SHIFT;
   localparam int BP_W          = 8;
   localparam int NUM_PAGES_DEF = 256;
   localparam int CFG_W         = 13;
   localparam int DATA_W        = 32;
   localparam int RA_W          = 4;
   localparam int NUM_EV        = 3;

   // Register offsets
   localparam logic [RA_W-1:0] REG_STATUS = 4'h0;
   localparam logic [RA_W-1:0] REG_MASK   = 4'h4;
   localparam logic [RA_W-1:0] REG_CFG    = 4'h8;
   localparam logic [RA_W-1:0] REG_BLKADR = 4'hC;

   // Status and mask bit positions
   localparam int EV_INT_BLK = 0;
   localparam int EV_EXT_BLK = 1;
   localparam int EV_PARITY  = 2;

   // Reset values
   localparam logic [CFG_W-1:0]  CFG_RST    = 13'h1FFF;
   localparam logic [NUM_EV-1:0] STATUS_RST = 3'h0;
   localparam logic [NUM_EV-1:0] MASK_RST   = 3'h0;
   localparam logic [ADDR_W-1:0] BLKADR_RST = 24'h000000;

   typedef enum logic [1:0] {
      OP_INT_WRITE = 2'b00,
      OP_INT_ERASE = 2'b01,
      OP_EXT_READ  = 2'b10,
      OP_EXT_WRITE = 2'b11
   } op_t;

   typedef struct packed {
      logic              valid;
      op_t               op;
      logic [ADDR_W-1:0] addr;
   } nvm_req_t;

   typedef struct packed {
      logic valid;
      logic grant;
      logic interlock;
   } nvm_resp_t;

   typedef struct packed {
      logic            globalCodeProtect;
      logic            globalWriteProtect;
      logic            segmentProtectDisable;
      logic            segmentDirection;
      logic            lastPageProtect;
      logic [BP_W-1:0] segmentBoundaryPage;
   } cfg_t;
endpackage : pmwg_pkg

//--- hw/config_shadow_check.sv
// Configuration cells with complemented shadow and continuous compare
`timescale 1ns/1ps
module config_shadow_check #(
   parameter int             W       = 13,
   parameter logic [W-1:0]   RST_VAL = '1
) (
   // Clock and reset
   input  logic         clk,
   input  logic         rst,
   // Load from configuration words
   input  logic         load,
   input  logic [W-1:0] loadVal,
   // Cell disruption
   input  logic [W-1:0] upset,
   // Results
   output logic [W-1:0] value,
   output logic         mismatch
);
   logic [W-1:0] cell_ff;
   logic [W-1:0] shadow_ff;
   logic [W-1:0] bitErr;
   logic         err_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         cell_ff <= RST_VAL;
      end else if (load) begin
         cell_ff <= loadVal;
      end else begin
         cell_ff <= cell_ff ^ upset;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         shadow_ff <= ~RST_VAL;
      end else if (load) begin
         shadow_ff <= ~loadVal;
      end
   end

   // Per-bit compare of cell and shadow
   for (genvar i = 0; i < W; i++) begin : g_cmp
      assign bitErr[i] = (cell_ff[i] == shadow_ff[i]);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         err_ff <= 1'b0;
      end else begin
         err_ff <= |bitErr;
      end
   end

   assign value    = cell_ff;
   assign mismatch = err_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_SHADOW_LOAD: assert property (
      load |=> (shadow_ff == ~cell_ff) && (cell_ff == $past(loadVal)))
      else $error("shadow not complement after load");
   AST_SHADOW_FLAG: assert property (
      (cell_ff != ~shadow_ff) |=> mismatch)
      else $error("shadow mismatch not flagged");
endmodule : config_shadow_check

//--- hw/program_memory_write_guard.sv
// Program memory access guard with segment and global protection
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
module program_memory_write_guard #(
   parameter int NUM_PAGES = pmwg_pkg::NUM_PAGES_DEF
) (
   // Clock and reset
   input  logic                            clk,
   input  logic                            rst,
   // Register port
   input  logic [pmwg_pkg::RA_W-1:0]       regAddr,
   input  logic [pmwg_pkg::DATA_W-1:0]     regWdata,
   input  logic                            regWr,
   input  logic                            regRd,
   output logic [pmwg_pkg::DATA_W-1:0]     regRdata,
   // Configuration word load
   input  logic                            cfgLoad,
   input  pmwg_pkg::cfg_t                  cfgWord,
   input  logic [pmwg_pkg::CFG_W-1:0]      cfgUpset,
   // Access request and answer
   input  pmwg_pkg::nvm_req_t              req,
   output pmwg_pkg::nvm_resp_t             resp,
   // Device reset and interrupt
   output logic                            devResetReq,
   output logic                            irq
);
   import pmwg_pkg::*;

   localparam logic [PG_W-1:0] LAST_PAGE = PG_W'(NUM_PAGES - 1);

   // Configuration state
   cfg_t                cfgNow;
   logic [CFG_W-1:0]    cfgBits;
   logic                parityErr;

   // Decision terms
   logic [PG_W-1:0]     reqPage;
   logic [PG_W-1:0]     bpPage;
   logic                isExt;
   logic                isWr;
   logic                segHit;
   logic                lastHit;
   logic                intBlock;
   logic                extBlock;
   logic                allow;

   // Registers
   nvm_resp_t           resp_ff;
   logic [NUM_EV-1:0]   status_ff;
   logic [NUM_EV-1:0]   nxt_status;
   logic [NUM_EV-1:0]   mask_ff;
   logic [NUM_EV-1:0]   nxt_mask;
   logic [NUM_EV-1:0]   evSet;
   logic [ADDR_W-1:0]   blkAddr_ff;
   logic                irq_ff;
   logic [DATA_W-1:0]   rdata_ff;
   logic                statClr;

   // Shadowed configuration cells
   config_shadow_check #(
      .W       (CFG_W),
      .RST_VAL (CFG_RST)
   ) u_cfg (
      .clk      (clk),
      .rst      (rst),
      .load     (cfgLoad),
      .loadVal  (cfgWord),
      .upset    (cfgUpset),
      .value    (cfgBits),
      .mismatch (parityErr)
   );

   assign cfgNow = cfg_t'(cfgBits);

   // Protection decision
   always_comb begin
      reqPage = req.addr[ADDR_W-1:PAGE_SHIFT];
      bpPage  = {{(PG_W-BP_W){1'b0}}, cfgNow.segmentBoundaryPage};
      isExt   = (req.op == OP_EXT_READ) || (req.op == OP_EXT_WRITE);
      isWr    = (req.op != OP_EXT_READ);
      segHit  = 1'b0;
      if (!cfgNow.segmentProtectDisable) begin
         if (cfgNow.segmentDirection) begin
            segHit = (reqPage >= bpPage);
         end else begin
            segHit = (reqPage <= bpPage);
         end
      end
      lastHit = !cfgNow.segmentProtectDisable &&
                !cfgNow.lastPageProtect &&
                (reqPage == LAST_PAGE);
      intBlock = !cfgNow.globalWriteProtect ||
                 segHit || lastHit;
      extBlock = cfgNow.globalCodeProtect;
      allow    = isExt ? !extBlock : !intBlock;
   end

   // Answer, one cycle after the request
   always_ff @(posedge clk) begin
      if (rst) begin
         resp_ff <= '0;
      end else begin
         resp_ff.valid     <= req.valid;
         resp_ff.grant     <= req.valid && allow;
         resp_ff.interlock <= req.valid && allow && isWr;
      end
   end

   // Address of the last refused request
   always_ff @(posedge clk) begin
      if (rst) begin
         blkAddr_ff <= BLKADR_RST;
      end else if (req.valid && !allow) begin
         blkAddr_ff <= req.addr;
      end
   end

   // Event detection
   always_comb begin
      evSet             = '0;
      evSet[EV_INT_BLK] = req.valid && !isExt && !allow;
      evSet[EV_EXT_BLK] = req.valid && isExt && !allow;
      evSet[EV_PARITY]  = parityErr;
   end

   assign statClr = regRd && (regAddr == REG_STATUS);

   // Sticky status, set wins over read clear
   always_comb begin
      nxt_status = evSet | (status_ff & {NUM_EV{!statClr}});
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         status_ff <= STATUS_RST;
      end else begin
         status_ff <= nxt_status;
      end
   end

   // Interrupt mask
   always_comb begin
      nxt_mask = mask_ff;
      if (regWr && (regAddr == REG_MASK)) begin
         nxt_mask = regWdata[NUM_EV-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mask_ff <= MASK_RST;
      end else begin
         mask_ff <= nxt_mask;
      end
   end

   // Interrupt output
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(nxt_status & nxt_mask);
      end
   end

   // Read data, valid only the cycle after a read
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_ff <= '0;
      end else if (regRd) begin
         case (regAddr)
            REG_STATUS: rdata_ff <= DATA_W'(status_ff);
            REG_MASK:   rdata_ff <= DATA_W'(mask_ff);
            REG_CFG:    rdata_ff <= DATA_W'(cfgBits);
            REG_BLKADR: rdata_ff <= DATA_W'(blkAddr_ff);
            default:    rdata_ff <= '0;
         endcase
      end else begin
         rdata_ff <= '0;
      end
   end

   assign regRdata    = rdata_ff;
   assign resp        = resp_ff;
   assign devResetReq = parityErr;
   assign irq         = irq_ff;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_EXT_REFUSED: assert property (
      req.valid && isExt && cfgNow.globalCodeProtect
      |=> resp.valid && !resp.grant && !resp.interlock)
      else $error("outside access passed under code protect");

   AST_EXT_OPEN: assert property (
      req.valid && isExt && !cfgNow.globalCodeProtect
      |=> resp.grant)
      else $error("outside access refused without code protect");

   AST_GWP_BLOCK: assert property (
      req.valid && !isExt && !cfgNow.globalWriteProtect
      |=> !resp.grant && !resp.interlock && status_ff[EV_INT_BLK])
      else $error("internal write passed under write protect");

   AST_SEG_LOW: assert property (
      req.valid && !isExt && !cfgNow.segmentProtectDisable &&
      !cfgNow.segmentDirection && (reqPage <= bpPage)
      |=> !resp.interlock)
      else $error("low segment write armed interlock");

   AST_SEG_HIGH: assert property (
      req.valid && !isExt && !cfgNow.segmentProtectDisable &&
      cfgNow.segmentDirection && (reqPage >= bpPage)
      |=> !resp.interlock)
      else $error("high segment write armed interlock");

   AST_SEG_EDGE: assert property (
      req.valid && !isExt && cfgNow.globalWriteProtect &&
      !cfgNow.segmentProtectDisable && cfgNow.lastPageProtect &&
      !cfgNow.segmentDirection && (reqPage == bpPage + 1'b1) &&
      (bpPage != LAST_PAGE)
      |=> resp.grant)
      else $error("page after boundary wrongly protected");

   AST_SEG_OFF: assert property (
      req.valid && !isExt && cfgNow.segmentProtectDisable &&
      cfgNow.globalWriteProtect
      |=> resp.grant && resp.interlock)
      else $error("segment protect acted while disabled");

   AST_GLOBAL_KEPT: assert property (
      req.valid && !isExt && !segHit && !cfgNow.globalWriteProtect
      |=> !resp.grant)
      else $error("segment setting undid global protect");

   AST_LAST_PAGE: assert property (
      req.valid && !isExt && !cfgNow.segmentProtectDisable &&
      !cfgNow.lastPageProtect && (reqPage == LAST_PAGE)
      |=> !resp.interlock)
      else $error("last page write armed interlock");

   AST_CFG_SRC: assert property (
      cfgLoad && (cfgUpset == '0) |=> cfgBits == $past(cfgWord))
      else $error("configuration not taken from words");

   AST_PARITY_RST: assert property (
      !cfgLoad && (cfgUpset != '0)
      |=> ##1 devResetReq ##1 status_ff[EV_PARITY])
      else $error("parity error did not request reset");

   AST_INTERLOCK: assert property (
      resp.interlock |-> resp.valid && resp.grant &&
      !$past(intBlock && !isExt))
      else $error("interlock armed for refused request");

   AST_RD_CLEAR: assert property (
      statClr && (evSet == '0) |=> status_ff == '0)
      else $error("status not cleared by read");

   AST_EVENT_SET: assert property (
      (evSet != '0)
      |=> (status_ff & $past(evSet)) == $past(evSet))
      else $error("event lost against read clear");

   AST_STICKY: assert property (
      !statClr
      |=> (status_ff & $past(status_ff)) == $past(status_ff))
      else $error("status bit dropped without read");

   AST_IRQ_LEVEL: assert property (
      irq == |(status_ff & mask_ff))
      else $error("interrupt level differs from status and mask");

   AST_MASK_WR: assert property (
      regWr && (regAddr == REG_MASK)
      |=> mask_ff == $past(regWdata[NUM_EV-1:0]))
      else $error("mask write not taken");

   AST_MASK_HOLD: assert property (
      !(regWr && (regAddr == REG_MASK))
      |=> $stable(mask_ff))
      else $error("mask changed without write");

   AST_RD_IDLE: assert property (
      !regRd
      |=> regRdata == '0)
      else $error("read data not zero outside read");

   AST_RD_STATUS: assert property (
      regRd && (regAddr == REG_STATUS)
      |=> regRdata == DATA_W'($past(status_ff)))
      else $error("status read data wrong");

   AST_RD_CFG: assert property (
      regRd && (regAddr == REG_CFG)
      |=> regRdata == DATA_W'($past(cfgBits)))
      else $error("configuration read data wrong");

   AST_BLKADR_SET: assert property (
      req.valid && !allow
      |=> blkAddr_ff == $past(req.addr))
      else $error("refused address not kept");

   AST_BLKADR_HOLD: assert property (
      !(req.valid && !allow)
      |=> $stable(blkAddr_ff))
      else $error("refused address changed without refusal");

   AST_RESP_VALID: assert property (
      req.valid |=> resp.valid)
      else $error("request not answered");

   AST_RESP_IDLE: assert property (
      !req.valid
      |=> !resp.valid && !resp.grant && !resp.interlock)
      else $error("answer without request");

   AST_EXEC_FREE: assert property (
      req.valid && !isExt && cfgNow.globalCodeProtect &&
      cfgNow.globalWriteProtect && cfgNow.segmentProtectDisable
      |=> resp.grant && resp.interlock)
      else $error("code protect blocked internal access");

   AST_HIGH_OPEN: assert property (
      req.valid && !isExt && cfgNow.globalWriteProtect &&
      !cfgNow.segmentProtectDisable && cfgNow.segmentDirection &&
      (reqPage < bpPage) &&
      (cfgNow.lastPageProtect || (reqPage != LAST_PAGE))
      |=> resp.grant)
      else $error("page below high segment wrongly protected");

   AST_LOW_OPEN: assert property (
      req.valid && !isExt && cfgNow.globalWriteProtect &&
      !cfgNow.segmentProtectDisable && !cfgNow.segmentDirection &&
      (reqPage > bpPage) &&
      (cfgNow.lastPageProtect || (reqPage != LAST_PAGE))
      |=> resp.grant)
      else $error("page above low segment wrongly protected");

   AST_CFG_WORDS: assert property (
      req.valid && isExt && cfgNow.globalCodeProtect &&
      (reqPage == LAST_PAGE)
      |=> !resp.grant)
      else $error("configuration words open under code protect");

   AST_RESET_HOLD: assert property (
      devResetReq && !$past(cfgLoad) && ($past(cfgUpset) == '0)
      |=> devResetReq)
      else $error("reset request dropped while mismatch stands");

   COV_EXT_BLOCK: cover property (
      req.valid && isExt && extBlock ##1 irq);
   COV_SEG_BLOCK: cover property (
      req.valid && !isExt && segHit && cfgNow.globalWriteProtect);
   COV_GRANT_WR: cover property (
      req.valid && !isExt && allow ##1 resp.interlock);
   COV_PARITY: cover property (
      devResetReq ##1 status_ff[EV_PARITY]);

endmodule : program_memory_write_guard

//--- testbench/nvm_sequencer_model.sv
// Model of the write/erase sequencer facing the guard
`timescale 1ns/1ps
module nvm_sequencer_model (
   // Clock and reset
   input  logic                clk,
   input  logic                rst,
   // Command from bench, traffic to and from guard
   input  pmwg_pkg::nvm_req_t  cmd,
   output pmwg_pkg::nvm_req_t  req,
   input  pmwg_pkg::nvm_resp_t resp,
   // Count of memory changes made
   output logic [15:0]         modCount_ff
);
   import pmwg_pkg::*;
   assign req = cmd;
   // Memory changes only on an armed interlock
   always_ff @(posedge clk) begin
      if (rst) begin
         modCount_ff <= 16'h0000;
      end else if (resp.valid && resp.interlock) begin
         modCount_ff <= modCount_ff + 16'h0001;
      end
   end
endmodule : nvm_sequencer_model

//--- testbench/tb.sv
// Self-checking bench for the program memory write guard
`timescale 1ns/1ps
module tb;
   import pmwg_pkg::*;
   localparam int NP = 64;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic [RA_W-1:0]   regAddr = '0;
   logic [DATA_W-1:0] regWdata = '0;
   logic              regWr = 1'b0;
   logic              regRd = 1'b0;
   logic [DATA_W-1:0] regRdata;
   logic              cfgLoad = 1'b0;
   cfg_t              cfgWord = '0;
   logic [CFG_W-1:0]  cfgUpset = '0;
   nvm_req_t          cmd = '0;
   nvm_req_t          req;
   nvm_resp_t         resp;
   logic              devResetReq;
   logic              irq;
   logic [15:0]       modCount;
   logic              maskOn = 1'b1;
   int                errTotal = 0;
   int                compares = 0;
   int                expMods = 0;
   cfg_t cfgs [8] = '{13'h0D05, 13'h1505, 13'h0905, 13'h0B05,
                      13'h0805, 13'h0C05, 13'h0900, 13'h1D05};
   logic [23:0] ads [6] = '{24'h000000, 24'h000A00, 24'h000BFF,
                            24'h000C00, 24'h003C00, 24'h007FFF};

   always #5 clk = ~clk;

   program_memory_write_guard #(.NUM_PAGES(NP)) u_dut (
      .clk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
      .cfgLoad, .cfgWord, .cfgUpset, .req, .resp, .devResetReq, .irq);

   nvm_sequencer_model u_nvm (
      .clk, .rst, .cmd, .req, .resp, .modCount_ff(modCount));

   task testDone;
      $display("errors %0d compares %0d", errTotal, compares);
      if (errTotal == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : testDone

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errTotal++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk

   task wr(input logic [RA_W-1:0] a, input logic [31:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr

   task rd(input logic [RA_W-1:0] a, input logic [31:0] exp);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 chk(regRdata, exp);
   endtask : rd

   task load(input cfg_t c);
      @(posedge clk);
      cfgLoad <= 1'b1;
      cfgWord <= c;
      @(posedge clk);
      cfgLoad <= 1'b0;
   endtask : load

   // Reference decision: {grant, interlock}
   function automatic logic [1:0] decide(input cfg_t c, input op_t op,
                                         input logic [23:0] a);
      logic [14:0] pg;
      logic        seg;
      logic        ok;
      pg = a[23:9];
      if (c.segmentDirection) begin
         seg = pg >= 15'(c.segmentBoundaryPage);
      end else begin
         seg = pg <= 15'(c.segmentBoundaryPage);
      end
      ok = c.globalWriteProtect;
      if (!c.segmentProtectDisable && seg) begin
         ok = 1'b0;
      end
      if (!c.segmentProtectDisable && !c.lastPageProtect && pg == 15'(NP-1))
         ok = 1'b0;
      if (op[1])
         ok = !c.globalCodeProtect;
      return {ok, ok && op != OP_EXT_READ};
   endfunction : decide

   task acc(input cfg_t c, input op_t op, input logic [23:0] a);
      logic [1:0] e;
      e = decide(c, op, a);
      @(posedge clk);
      cmd <= '{1'b1, op, a};
      @(posedge clk);
      cmd.valid <= 1'b0;
      #1 chk(32'(resp), {29'h0, 1'b1, e});
      expMods += int'(e[0]);
      @(posedge clk);
      #1 chk(irq, !e[1] && maskOn);
      if (!e[1]) begin
         rd(REG_STATUS, op[1] ? 32'h2 : 32'h1);
         rd(REG_BLKADR, {8'h00, a});
      end
   endtask : acc

   initial begin
      repeat (30000) @(posedge clk);
      errTotal++;
      testDone;
   end

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      #1 chk(32'(resp), 32'h0);
      chk(irq, 32'h0);
      chk(devResetReq, 32'h0);
      rd(REG_CFG, 32'h1FFF);
      rd(REG_MASK, 32'h0);
      rd(REG_STATUS, 32'h0);
      rd(REG_BLKADR, 32'h0);
      rd(4'h2, 32'h0);
      wr(REG_CFG, 32'h0);
      rd(REG_CFG, 32'h1FFF);
      wr(REG_MASK, 32'h7);
      rd(REG_MASK, 32'h7);
      foreach (cfgs[i]) begin
         load(cfgs[i]);
         rd(REG_CFG, 32'(cfgs[i]));
         for (int o = 0; o < 4; o++) begin
            foreach (ads[j]) acc(cfgs[i], op_t'(o), ads[j]);
         end
      end
      // Masked event leaves irq low
      wr(REG_MASK, 32'h0);
      maskOn = 1'b0;
      load(cfgs[1]);
      acc(cfgs[1], OP_INT_ERASE, 24'h000A00);
      // Cell upset forces device reset request
      @(posedge clk);
      cfgUpset <= 13'h0001;
      @(posedge clk);
      cfgUpset <= 13'h0000;
      repeat (3) @(posedge clk);
      #1 chk(devResetReq, 1'b1);
      rd(REG_STATUS, 32'h4);
      load(cfgs[0]);
      @(posedge clk);
      #1 chk(devResetReq, 1'b0);
      chk(32'(modCount), 32'(expMods));
      testDone;
   end
endmodule : tb
